// ==== design/ddc_defs.svh ====
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH

// register byte offsets
`define DDC_OFF_GCTL   12'h000
`define DDC_OFF_STAT   12'h004
`define DDC_OFF_CMD    12'h008
`define DDC_OFF_SRC    12'h00c
`define DDC_OFF_DST    12'h010
`define DDC_OFF_CNT    12'h014
`define DDC_OFF_RT     12'h018
`define DDC_OFF_STRD   12'h01c
`define DDC_OFF_DPTR   12'h020
`define DDC_OFF_BELL   12'h024
`define DDC_OFF_CPEND  12'h028
`define DDC_OFF_DPEND  12'h02c
`define DDC_OFF_PCH    12'h030
`define DDC_OFF_CMASK  12'h034
`define DDC_OFF_SMASK  12'h038
`define DDC_OFF_SPEND  12'h03c

// global_control fields
`define DDC_G_EN       0
`define DDC_G_AR       2
`define DDC_G_HLT      3
// channel_status fields
`define DDC_S_CE       0
`define DDC_S_AR       2
`define DDC_S_HLT      3
`define DDC_S_TT       4
`define DDC_S_COMPLETED_DESC_OFFSET     15:8
`define DDC_S_NDES     30
`define DDC_S_LONG_DESCRIPTOR_SELECT     31
// channel_command / descriptor word 1 fields
`define DDC_C_LINK     0
`define DDC_C_TIE      1
`define DDC_C_STRIDE_ENABLE     2
`define DDC_C_TSZ      10:8
`define DDC_C_REQUEST_INTERVAL_LENGTH     19:16
`define DDC_C_DINC     22
`define DDC_C_SINC     23
// descriptor words 4..6 fields
`define DDC_D_OFF      31:24
`define DDC_D_CNT      23:0
`define DDC_D_TSTR     31:16
`define DDC_D_SSTR     15:0
`define DDC_D_RT       5:0
// descriptor pointer split
`define DDC_P_BASE     31:12
`define DDC_P_OFF      11:4
// descriptor word indices
`define DDC_W_CMD      3'h0
`define DDC_W_SRC      3'h1
`define DDC_W_DST      3'h2
`define DDC_W_CNT      3'h3
`define DDC_W_STRD     3'h4
`define DDC_W_RT       3'h5
`define DDC_LAST_SHORT 3'h3
`define DDC_LAST_LONG  3'h5
// encodings
`define DDC_RT_AUTO    6'h08
`define DDC_TSZ_REQUEST_INTERVAL_LENGTH   3'h7
`define DDC_WORD_STEP  32'h4

`endif

// ==== design/ddc_pkg.sv ====
`default_nettype none
package ddc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FETCH = 6'h02,
    ST_WAIT  = 6'h04,
    ST_READ  = 6'h08,
    ST_WRITE = 6'h10,
    ST_END   = 6'h20
  } ddc_state_e;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        err;
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } ddc_port_s;
endpackage
`default_nettype wire

// ==== design/ddc_mem_if.sv ====
`default_nettype none
interface ddc_mem_if;
  logic        req;
  logic        we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        done;
  logic        err;
  logic [31:0] rdata;
  modport eng  (output req, we, addr, wdata, input done, err, rdata);
  modport port (input req, we, addr, wdata, output done, err, rdata);
endinterface
`default_nettype wire

// ==== design/ddc_mem_port.sv ====
`default_nettype none
module ddc_mem_port
  import ddc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  ddc_mem_if.port          p,
  output var  logic        mem_req,
  output var  logic        mem_we,
  output var  logic [31:0] mem_addr,
  output var  logic [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err
);
  ddc_port_s r;
  ddc_port_s next_r;

  // done blocks a restart for one cycle so the engine can drop or change its request
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.err  = 1'b0;
    if (!r.busy) begin
      if (p.req && !r.done) begin
        next_r.busy  = 1'b1;
        next_r.req   = 1'b1;
        next_r.we    = p.we;
        next_r.addr  = p.addr;
        next_r.wdata = p.wdata;
      end
    end else if (mem_ack) begin
      next_r.busy  = 1'b0;
      next_r.req   = 1'b0;
      next_r.done  = 1'b1;
      next_r.err   = mem_err;
      next_r.rdata = mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign p.done    = r.done;
  assign p.err     = r.err;
  assign p.rdata   = r.rdata;
  assign mem_req   = r.req;
  assign mem_we    = r.we;
  assign mem_addr  = r.addr;
  assign mem_wdata = r.wdata;
endmodule
`default_nettype wire

// ==== design/ddc_channel.sv ====
// Notes on behaviour
// RULE1: descriptor word 4 holds next offset 31:24 and count 23:0; words 2,3 addresses.
// RULE2: word 5 holds target stride 31:16, source stride 15:0; word 6 request type 5:0.
// RULE3: in stride mode each sub-block starts past previous end plus its stride.
// RULE4: software checks global and channel error, halt, done flags and count are zero.
// RULE5: without descriptors software programs channel registers, then sets both enables.
// RULE6: request type 0x8 starts transfer once both enables are set.
// RULE7: other request types wait idle for a detected peripheral request.
// RULE8: count drops by one per unit; transfer ends normally at zero.
// RULE9: normal end with interrupt enable sets channel pending bit and raises interrupt.
// RULE10: bus address error suspends, sets both address-error flags and pending bit.
// RULE11: peripheral error suspends channel and sets channel and global halt flags.
// RULE12: offset of last completed descriptor is copied into status bits 15:8.
// RULE13: clearing channel enable mid-chain ends the chain after current unit.
// RULE14: clearing link enable mid-chain stops after current descriptor.
// RULE15: a zero write to link enable may be lost; software rewrites or reads back.
// RULE16: non-final descriptor with interrupt enable sets descriptor pending bit instead.
// RULE17: per request move one unit, or interval length units when size field is 7.
// RULE18: software keeps per-request amount within what the peripheral expects.
// RULE19: software loads handler firmware, sets enable and select, clears irq mask.
// RULE20: local handler clears the transfer-done flag to remove the channel interrupt.
// RULE21: unmasked soft pending bit raises soft interrupt; handler clears it.
// RULE22: descriptor word 1 carries increments, interval, widths, size, stride, irq, link.
// RULE23: unlinked descriptor end sets done flag; linked one fetches the next.
// RULE24: software aligns first descriptor to 16 or 32 bytes.
// RULE25: doorbell bit clears automatically when descriptor fetch begins.
// RULE26: error, halt and done flags stay until cleared; suspension never self-resumes.
//
// Decided for this implementation: the register offsets and the APB register port.
`include "ddc_defs.svh"
`default_nettype none
module ddc_channel
  import ddc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        dreq,
  output var  logic        dack,
  input  wire logic        periph_err,
  output var  logic        mem_req,
  output var  logic        mem_we,
  output var  logic [31:0] mem_addr,
  output var  logic [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  output var  logic        irq,
  output var  logic        mcu_chan_irq,
  output var  logic        soft_irq
);
  typedef struct packed {
    ddc_state_e  st;
    logic        ge, g_ar, g_hlt, ce, c_ar, c_hlt, tt, ndes, long_descriptor_select;
    logic [7:0]  completed_desc_offset;
    logic [31:0] cmd, src, dst;
    logic [23:0] cnt;
    logic [7:0]  doff, foff;
    logic [5:0]  rtype;
    logic [31:0] stride, dptr;
    logic        bell, cpend, descriptor_irq_pending_reg, pch, cmask, smask, spend;
    logic [2:0]  widx;
    logic [4:0]  beats;
    logic [31:0] data, prdata;
    logic        pready, pslverr, dack, irq, mcu_irq, soft_irq;
    logic        dreq_s1, dreq_s2, dreq_s3, rq, perr_s1, perr_s2;
  } ddc_chan_s;

  ddc_chan_s r;
  ddc_chan_s next_r;
  logic      wr;
  logic      rd;
  logic      busy_flags;

  ddc_mem_if m ();

  ddc_mem_port u_port (
    .pclk      (pclk),
    .presetn   (presetn),
    .p         (m.port),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack),
    .mem_err   (mem_err)
  );

  // address step per unit; the bus always moves one word per unit
  function automatic logic [31:0] unit_step(input logic [31:0] cmd);
    if (cmd[`DDC_C_TSZ] == `DDC_TSZ_REQUEST_INTERVAL_LENGTH) return `DDC_WORD_STEP;
    return 32'h1 << cmd[`DDC_C_TSZ];
  endfunction

  function automatic logic [4:0] burst_len(input logic [31:0] cmd);
    if (cmd[`DDC_C_TSZ] != `DDC_TSZ_REQUEST_INTERVAL_LENGTH) return 5'h01;
    if (cmd[`DDC_C_REQUEST_INTERVAL_LENGTH] == 4'h0) return 5'h01;
    return {1'b0, cmd[`DDC_C_REQUEST_INTERVAL_LENGTH]};
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return (a[1:0] == 2'h0) && (a <= `DDC_OFF_SPEND);
  endfunction

  function automatic logic [31:0] rd_word(input ddc_chan_s s, input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      `DDC_OFF_GCTL: begin
        v[`DDC_G_EN]  = s.ge;
        v[`DDC_G_AR]  = s.g_ar;
        v[`DDC_G_HLT] = s.g_hlt;
      end
      `DDC_OFF_STAT: begin
        v[`DDC_S_CE]   = s.ce;
        v[`DDC_S_AR]   = s.c_ar;
        v[`DDC_S_HLT]  = s.c_hlt;
        v[`DDC_S_TT]   = s.tt;
        v[`DDC_S_COMPLETED_DESC_OFFSET] = s.completed_desc_offset;
        v[`DDC_S_NDES] = s.ndes;
        v[`DDC_S_LONG_DESCRIPTOR_SELECT] = s.long_descriptor_select;
      end
      `DDC_OFF_CMD:   v = s.cmd;
      `DDC_OFF_SRC:   v = s.src;
      `DDC_OFF_DST:   v = s.dst;
      `DDC_OFF_CNT:   v[`DDC_D_CNT] = s.cnt;
      `DDC_OFF_RT:    v[`DDC_D_RT] = s.rtype;
      `DDC_OFF_STRD:  v = s.stride;
      `DDC_OFF_DPTR:  v = s.dptr;
      `DDC_OFF_BELL:  v[0] = s.bell;
      `DDC_OFF_CPEND: v[0] = s.cpend;
      `DDC_OFF_DPEND: v[0] = s.descriptor_irq_pending_reg;
      `DDC_OFF_PCH:   v[0] = s.pch;
      `DDC_OFF_CMASK: v[0] = s.cmask;
      `DDC_OFF_SMASK: v[0] = s.smask;
      `DDC_OFF_SPEND: v[0] = s.spend;
      default:        v = 32'h0;
    endcase
    return v;
  endfunction

  assign wr         = psel && penable && r.pready && pwrite;
  assign rd         = psel && penable && r.pready && !pwrite;
  assign busy_flags = r.g_ar || r.g_hlt || r.c_ar || r.c_hlt || r.tt;

  assign m.req   = (r.st == ST_FETCH) || (r.st == ST_READ) || (r.st == ST_WRITE);
  assign m.we    = (r.st == ST_WRITE);
  assign m.wdata = r.data;
  assign m.addr  = (r.st == ST_FETCH) ?
                   {r.dptr[`DDC_P_BASE], r.foff, 4'h0} + {27'h0, r.widx, 2'h0} :
                   (r.st == ST_READ) ? r.src : r.dst;

  always_comb begin
    next_r         = r;
    next_r.dreq_s1 = dreq;
    next_r.dreq_s2 = r.dreq_s1;
    next_r.dreq_s3 = r.dreq_s2;
    next_r.perr_s1 = periph_err;
    next_r.perr_s2 = r.perr_s1;
    next_r.dack    = 1'b0;
    next_r.pready  = psel && !penable;
    next_r.pslverr = psel && !penable && !mapped(paddr);
    if (psel && !penable) next_r.prdata = rd_word(r, paddr);
    // software writes first, so hardware sets further down win over a clear
    if (wr) begin
      unique case (paddr)
        `DDC_OFF_GCTL: begin
          next_r.ge    = pwdata[`DDC_G_EN];
          next_r.g_ar  = r.g_ar & pwdata[`DDC_G_AR];
          next_r.g_hlt = r.g_hlt & pwdata[`DDC_G_HLT];
        end
        `DDC_OFF_STAT: begin
          next_r.ce    = pwdata[`DDC_S_CE];
          next_r.c_ar  = r.c_ar & pwdata[`DDC_S_AR];
          next_r.c_hlt = r.c_hlt & pwdata[`DDC_S_HLT];
          next_r.tt    = r.tt & pwdata[`DDC_S_TT]; // RULE20
          next_r.ndes  = pwdata[`DDC_S_NDES];
          next_r.long_descriptor_select  = pwdata[`DDC_S_LONG_DESCRIPTOR_SELECT];
        end
        `DDC_OFF_CMD:   next_r.cmd = pwdata; // RULE14
        `DDC_OFF_SRC:   next_r.src = pwdata;
        `DDC_OFF_DST:   next_r.dst = pwdata;
        `DDC_OFF_CNT:   next_r.cnt = pwdata[`DDC_D_CNT];
        `DDC_OFF_RT:    next_r.rtype = pwdata[`DDC_D_RT];
        `DDC_OFF_STRD:  next_r.stride = pwdata;
        `DDC_OFF_DPTR:  next_r.dptr = pwdata;
        `DDC_OFF_BELL:  next_r.bell = r.bell | pwdata[0];
        `DDC_OFF_CPEND: next_r.cpend = r.cpend & ~pwdata[0];
        `DDC_OFF_PCH:   next_r.pch = pwdata[0];
        `DDC_OFF_CMASK: next_r.cmask = pwdata[0];
        `DDC_OFF_SMASK: next_r.smask = pwdata[0];
        `DDC_OFF_SPEND: next_r.spend = pwdata[0]; // RULE21
        default: ;
      endcase
    end
    // descriptor pending is read-only and clears when read
    if (rd && paddr == `DDC_OFF_DPEND) next_r.descriptor_irq_pending_reg = 1'b0;
    // a request edge is held until taken, a new edge wins over the take
    next_r.rq = r.rq || (r.dreq_s2 && !r.dreq_s3);
    if (r.st != ST_IDLE && r.perr_s2) begin
      next_r.c_hlt = 1'b1; // RULE11
      next_r.g_hlt = 1'b1; // RULE11
      next_r.st    = ST_IDLE; // RULE26
    end else begin
      unique case (r.st)
        ST_IDLE: begin
          if (r.ge && r.ce && !busy_flags) begin // RULE26
            if (!r.ndes && r.bell) begin
              next_r.bell = 1'b0; // RULE25
              next_r.widx = 3'h0;
              next_r.foff = r.dptr[`DDC_P_OFF];
              next_r.st   = ST_FETCH;
            end else if (r.ndes && r.cnt != 24'h0) begin
              next_r.st = ST_WAIT;
            end
          end
        end
        ST_FETCH: begin
          if (m.done && m.err) begin
            next_r.c_ar  = 1'b1;
            next_r.g_ar  = 1'b1;
            next_r.cpend = 1'b1;
            next_r.st    = ST_IDLE;
          end else if (m.done) begin
            unique case (r.widx)
              `DDC_W_CMD:  next_r.cmd = m.rdata; // RULE22
              `DDC_W_SRC:  next_r.src = m.rdata; // RULE1
              `DDC_W_DST:  next_r.dst = m.rdata; // RULE1
              `DDC_W_CNT: begin
                next_r.doff = m.rdata[`DDC_D_OFF]; // RULE1
                next_r.cnt  = m.rdata[`DDC_D_CNT]; // RULE1
              end
              `DDC_W_STRD: next_r.stride = m.rdata; // RULE2
              `DDC_W_RT:   next_r.rtype = m.rdata[`DDC_D_RT]; // RULE2
              default: ;
            endcase
            next_r.widx = r.widx + 3'h1;
            if (r.widx == (r.long_descriptor_select ? `DDC_LAST_LONG : `DDC_LAST_SHORT)) next_r.st = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!r.ce) begin
            next_r.st = ST_IDLE;
          end else if (r.cnt == 24'h0) begin
            next_r.st = ST_END;
          end else if (r.rtype == `DDC_RT_AUTO) begin // RULE6
            next_r.beats = burst_len(r.cmd);
            next_r.st    = ST_READ;
          end else if (r.rq) begin // RULE7
            next_r.rq    = r.dreq_s2 && !r.dreq_s3;
            next_r.dack  = 1'b1;
            next_r.beats = burst_len(r.cmd); // RULE17
            next_r.st    = ST_READ;
          end
        end
        ST_READ: begin
          if (m.done && m.err) begin
            next_r.c_ar  = 1'b1; // RULE10
            next_r.g_ar  = 1'b1; // RULE10
            next_r.cpend = 1'b1; // RULE10
            next_r.st    = ST_IDLE;
          end else if (m.done) begin
            next_r.data = m.rdata;
            next_r.st   = ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (m.done && m.err) begin
            next_r.c_ar  = 1'b1; // RULE10
            next_r.g_ar  = 1'b1; // RULE10
            next_r.cpend = 1'b1; // RULE10
            next_r.st    = ST_IDLE;
          end else if (m.done) begin
            next_r.cnt   = r.cnt - 24'h1; // RULE8
            next_r.beats = r.beats - 5'h1;
            if (r.cmd[`DDC_C_SINC]) next_r.src = r.src + unit_step(r.cmd);
            if (r.cmd[`DDC_C_DINC]) next_r.dst = r.dst + unit_step(r.cmd);
            if (r.cnt == 24'h1) begin
              next_r.st = ST_END; // RULE8
            end else if (!r.ce) begin
              next_r.st = ST_IDLE; // RULE13
            end else if (r.beats == 5'h1) begin
              // a sub-block is one request's worth of units
              if (r.cmd[`DDC_C_STRIDE_ENABLE]) begin
                next_r.src = next_r.src + {16'h0, r.stride[`DDC_D_SSTR]}; // RULE3
                next_r.dst = next_r.dst + {16'h0, r.stride[`DDC_D_TSTR]}; // RULE3
              end
              next_r.st = ST_WAIT;
            end else begin
              next_r.st = ST_READ;
            end
          end
        end
        ST_END: begin
          next_r.completed_desc_offset = r.doff; // RULE12
          if (!r.ndes && r.cmd[`DDC_C_LINK] && r.ce) begin // RULE14
            if (r.cmd[`DDC_C_TIE]) next_r.descriptor_irq_pending_reg = 1'b1; // RULE16
            next_r.foff = r.doff; // RULE23
            next_r.widx = 3'h0;
            next_r.st   = ST_FETCH;
          end else begin
            next_r.tt = 1'b1; // RULE23
            if (r.cmd[`DDC_C_TIE]) next_r.cpend = 1'b1; // RULE9
            next_r.st = ST_IDLE;
          end
        end
      endcase
    end
    next_r.irq      = next_r.cpend || next_r.descriptor_irq_pending_reg; // RULE9
    next_r.mcu_irq  = next_r.pch && !next_r.cmask && next_r.tt && next_r.cmd[`DDC_C_TIE];
    next_r.soft_irq = next_r.spend && !next_r.smask; // RULE21
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r    <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata       = r.prdata;
  assign pready       = r.pready;
  assign pslverr      = r.pslverr;
  assign dack         = r.dack;
  assign irq          = r.irq;
  assign mcu_chan_irq = r.mcu_irq;
  assign soft_irq     = r.soft_irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BELL_CLEARS: assert property ( // RULE25
    (r.st == ST_IDLE && next_r.st == ST_FETCH && !wr) |=> !r.bell)
    else $error("doorbell not cleared at fetch start");
  AST_AUTO_START: assert property ( // RULE6
    (r.st == ST_WAIT && r.ce && r.cnt != 24'h0 && r.rtype == `DDC_RT_AUTO && !r.perr_s2)
    |=> r.st == ST_READ)
    else $error("auto request did not start");
  AST_NO_REQ_HOLD: assert property ( // RULE7
    (r.st == ST_WAIT && r.rtype != `DDC_RT_AUTO && !r.rq) |=> r.st != ST_READ)
    else $error("started without a request");
  AST_COUNT_DEC: assert property ( // RULE8
    (r.st == ST_WRITE && m.done && !m.err && !r.perr_s2 && !wr) |=> r.cnt == $past(r.cnt) - 24'h1)
    else $error("count not decremented");
  AST_ADDR_ERR: assert property ( // RULE10
    (m.done && m.err && r.st != ST_IDLE && !r.perr_s2) |=> (r.c_ar && r.g_ar && r.cpend)[*2])
    else $error("address error flags not set");
  AST_HALT: assert property ( // RULE11
    (r.st != ST_IDLE && r.perr_s2) |=> r.c_hlt && r.g_hlt && r.st == ST_IDLE)
    else $error("peripheral error did not halt");
  AST_COMPLETED_DESC_OFFSET: assert property ( // RULE12
    (r.st == ST_END && !r.perr_s2) |=> r.completed_desc_offset == $past(r.doff))
    else $error("completed offset not copied");
  AST_TT_STICKY: assert property ( // RULE26
    (r.tt && !(wr && paddr == `DDC_OFF_STAT)) |=> r.tt)
    else $error("done flag dropped by itself");
  AST_SOFT_IRQ: assert property ( // RULE21
    (wr && paddr == `DDC_OFF_SPEND && pwdata[0] && !r.smask) |=> soft_irq)
    else $error("soft interrupt not raised");
  AST_DESC_PEND: assert property ( // RULE16
    (r.st == ST_END && !r.ndes && r.cmd[`DDC_C_LINK] && r.cmd[`DDC_C_TIE] && r.ce
     && !r.perr_s2) |=> r.descriptor_irq_pending_reg && r.st == ST_FETCH)
    else $error("descriptor pending not set on linked end");

  COV_DESC_DONE:   cover property (r.st == ST_END && !r.ndes ##1 r.tt);
  COV_CHAIN:       cover property (r.st == ST_END ##1 r.st == ST_FETCH);
  COV_STRIDE:      cover property (r.st == ST_WRITE && m.done && r.cmd[`DDC_C_STRIDE_ENABLE]);
  COV_PERIPH_HALT: cover property (r.st == ST_WAIT && r.perr_s2);
endmodule
`default_nettype wire

// ==== test/ddc_mem_model.sv ====
`default_nettype none
module ddc_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  lat,
  output var  logic [31:0] mem_rdata,
  output var  logic        mem_ack,
  output var  logic        mem_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255];
  logic [1:0]  wait_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt  <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      // data means nothing without ack, so never let it sit still
      mem_rdata <= ~mem_rdata;
      // req may still be high in the ack cycle; do not answer it twice
      if (mem_req && !mem_ack) begin
        if (wait_cnt == lat) begin
          wait_cnt  <= 2'h0;
          mem_ack   <= 1'b1;
          // upper half of the map is unpopulated
          mem_err   <= mem_addr[31];
          mem_rdata <= mem[mem_addr[9:2]];
          if (mem_we && !mem_addr[31]) begin
            mem[mem_addr[9:2]] <= mem_wdata;
          end
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/descriptor_dma_channel_bench.sv ====
`include "ddc_defs.svh"
`default_nettype none
module descriptor_dma_channel_bench import ddc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, dreq, periph_err, ev;
  logic        pready, pslverr, dack, mem_req, mem_we, mem_ack, mem_err;
  logic        irq, mcu_chan_irq, soft_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rv;
  logic [31:0] srcv [0:3];
  logic [1:0]  lat;
  int          miscompares, comparisons, cycles, dacks, seed, n, k;

  ddc_channel uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dreq, .dack, .periph_err, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .mem_err, .irq, .mcu_chan_irq, .soft_irq);
  ddc_mem_model model (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat,
    .mem_rdata, .mem_ack, .mem_err);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (dack === 1'b1) dacks++;
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // status image: mode bits, completed offset, flags {done, halt, addr err}, enable
  function automatic logic [31:0] stat_exp(input logic [31:0] mode, input logic [7:0] off,
                                           input logic [2:0] fl);
    return mode | {16'h0, off, 3'h0, fl, 2'b01};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench's cycle ceiling ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_status();
    do begin
      apb(1'b0, `DDC_OFF_STAT, 32'h0);
    end while ((rv & 32'h1c) == 32'h0);
  endtask

  task automatic rst();
    presetn <= 1'b0;
    dacks = 0;
    lat <= 2'($random(seed));
    for (k = 0; k < 4; k++) srcv[k] = $random(seed);
    for (k = 0; k < 4; k++) model.mem[32+k] = srcv[k];
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic check_idle();
    apb(1'b0, `DDC_OFF_GCTL, 32'h0);
    chk("global", 32'h0, rv);
    apb(1'b0, `DDC_OFF_STAT, 32'h0);
    chk("status", 32'h0, rv);
    apb(1'b0, `DDC_OFF_CNT, 32'h0);
    chk("count", 32'h0, rv);
  endtask

  task automatic launch(input logic [31:0] src, input logic [31:0] cnt,
                        input logic [31:0] cmd, input logic [31:0] rt);
    check_idle();
    apb(1'b1, `DDC_OFF_SRC, src);
    apb(1'b1, `DDC_OFF_DST, 32'hc0);
    apb(1'b1, `DDC_OFF_CNT, cnt);
    apb(1'b1, `DDC_OFF_RT, rt);
    apb(1'b1, `DDC_OFF_STAT, 32'h4000_0000);
    apb(1'b1, `DDC_OFF_CMD, cmd);
    apb(1'b0, `DDC_OFF_CMD, 32'h0);
    chk("cmd", cmd, rv);
    apb(1'b1, `DDC_OFF_GCTL, 32'h1);
    apb(1'b1, `DDC_OFF_STAT, 32'h4000_0001);
  endtask

  task automatic chk_copy(input int cnt);
    for (k = 0; k < cnt; k++) chk("copy", srcv[k], model.mem[48+k]);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, dreq, periph_err, paddr, pwdata, lat} = '0;
    {miscompares, comparisons, cycles, dacks} = '0;
    seed = 32'h621b;
    rst();
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped err", 32'h1, ev);
    chk("unmapped data", 32'h0, rv);
    // auto request, random length, interrupt enabled
    n = ($random(seed) & 3) + 1;
    launch(32'h80, n, 32'h00c0_0202, 32'h8);
    wait_status();
    chk("done status", stat_exp(32'h4000_0000, 8'h0, 3'b100), rv);
    chk_copy(n);
    apb(1'b0, `DDC_OFF_CNT, 32'h0);
    chk("end count", 32'h0, rv);
    apb(1'b0, `DDC_OFF_CPEND, 32'h0);
    chk("chan pend", 32'h1, rv & 32'h1);
    chk("irq", 32'h1, irq);
    apb(1'b1, `DDC_OFF_PCH, 32'h1);
    apb(1'b1, `DDC_OFF_CMASK, 32'h0);
    chk("mcu irq", 32'h1, mcu_chan_irq);
    apb(1'b1, `DDC_OFF_STAT, 32'h4000_0001);
    repeat (2) @(posedge pclk);
    chk("mcu irq off", 32'h0, mcu_chan_irq);
    apb(1'b1, `DDC_OFF_SMASK, 32'h0);
    apb(1'b1, `DDC_OFF_SPEND, 32'h1);
    repeat (2) @(posedge pclk);
    chk("soft irq", 32'h1, soft_irq);
    apb(1'b1, `DDC_OFF_SPEND, 32'h0);
    repeat (2) @(posedge pclk);
    chk("soft irq off", 32'h0, soft_irq);
    // peripheral request, size field 7: one request moves interval-length units
    rst();
    launch(32'h80, 32'h2, 32'h00c2_0700, 32'h4);
    repeat (20) @(posedge pclk);
    apb(1'b0, `DDC_OFF_CNT, 32'h0);
    chk("idle count", 32'h2, rv);
    dreq <= 1'b1;
    repeat (4) @(posedge pclk);
    dreq <= 1'b0;
    wait_status();
    chk("dack", 32'h1, dacks);
    chk_copy(2);
    apb(1'b0, `DDC_OFF_CPEND, 32'h0);
    chk("no pend", 32'h0, rv);
    // address error with interrupt enable clear
    rst();
    launch(32'h8000_0000, 32'h1, 32'h00c0_0200, 32'h8);
    wait_status();
    repeat (30) @(posedge pclk);
    apb(1'b0, `DDC_OFF_STAT, 32'h0);
    chk("ar status", stat_exp(32'h4000_0000, 8'h0, 3'b001), rv);
    apb(1'b0, `DDC_OFF_GCTL, 32'h0);
    chk("ar global", 32'h5, rv);
    apb(1'b0, `DDC_OFF_CPEND, 32'h0);
    chk("ar pend", 32'h1, rv & 32'h1);
    // peripheral fault while waiting for a request
    rst();
    launch(32'h80, 32'h2, 32'h00c0_0202, 32'h4);
    periph_err <= 1'b1;
    wait_status();
    periph_err <= 1'b0;
    chk("halt status", stat_exp(32'h4000_0000, 8'h0, 3'b010), rv);
    apb(1'b0, `DDC_OFF_GCTL, 32'h0);
    chk("halt global", 32'h9, rv);
    // two chained long descriptors, auto request
    rst();
    n = ($random(seed) & 3) + 1;
    model.mem[64] = 32'h00c0_0203;
    model.mem[65] = 32'h80;
    model.mem[66] = 32'hc0;
    model.mem[67] = {8'h5a, 24'(n)};
    model.mem[68] = 32'h0;
    model.mem[69] = 32'h8;
    // second, final descriptor at offset 0x5a: two strided units to 0xd0
    for (k = 0; k < 6; k++) model.mem[104+k] = model.mem[64+k];
    model.mem[104] = 32'h00c0_0206;
    model.mem[106] = 32'hd0;
    model.mem[107] = {8'h33, 24'h2};
    model.mem[108] = 32'h0004_0004;
    check_idle();
    apb(1'b1, `DDC_OFF_DPTR, 32'h100);
    apb(1'b1, `DDC_OFF_BELL, 32'h1);
    apb(1'b1, `DDC_OFF_GCTL, 32'h1);
    apb(1'b1, `DDC_OFF_STAT, 32'h8000_0001);
    wait_status();
    chk("desc status", stat_exp(32'h8000_0000, 8'h33, 3'b100), rv);
    chk_copy(n);
    chk("copy2", srcv[0], model.mem[52]);
    chk("stride", srcv[2], model.mem[54]);
    apb(1'b0, `DDC_OFF_BELL, 32'h0);
    chk("bell", 32'h0, rv & 32'h1);
    apb(1'b0, `DDC_OFF_DPEND, 32'h0);
    chk("desc pend", 32'h1, rv);
    apb(1'b0, `DDC_OFF_DPEND, 32'h0);
    chk("desc pend read", 32'h0, rv);
    apb(1'b0, `DDC_OFF_CPEND, 32'h0);
    chk("final pend", 32'h1, rv & 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
